//--- spi_crc_command_handler.sv
// crc protected spi instruction engine with register and message memory
//
// Contract
// - a frame runs from chip select falling to chip select rising
// - checked write: code 0b1010, 12-bit address, count (bytes, words in message memory), data, crc
// - checked register write commits each byte at the falling edge ending it
// - checked writes compare crc at the end and flag a mismatch
// - chip select rising before the last crc byte flags a form error; the code flags it only once both header bytes are in
// - verified write: code 0b1100, address, one byte (four in message memory), crc, no count
// - verified register write holds the byte until the crc passes
// - failed verified register write leaves the register, flags error
// - checked read: code 0b1011, address, count (bytes, words in message memory), data out, crc out
// - message memory addresses have their two low bits forced to zero
// - memory checked read fetches a word after the count and each fourth byte
// - checked reads only send the crc and never flag a mismatch
// - chip select rising before the last crc byte out flags form error; the code flags it only once both header bytes are in
// - memory checked write stores each full word, never a partial one
// - memory verified write takes four bytes, commits after crc match
// - failed memory verified write leaves the word and flags error
// - crc starts at all ones at every frame start, beside the shifter
// - crc uses generator polynomial 0x8005
// - crc covers command, address, count and data in wire order
// - on mismatch the computed crc is kept in the status register
`timescale 1ns/1ps
`include "spi_crc_params.svh"
module spi_crc_command_handler #(
  parameter int MEM_DEPTH = 4096
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        sdi,
  input  wire logic        clearCrcError,
  input  wire logic        clearFormError,
  output logic             sdo,
  output logic             crcErrorFlag,
  output logic             crcFormErrorFlag,
  output logic [15:0]      crcStatus
);
  initial begin
    if (MEM_DEPTH != 4096) begin
      $error("MEM_DEPTH must cover the full 12-bit address space");
    end
  end

  // ******************************
  // storage and crc step
  // ******************************
  logic [7:0] mem [0:MEM_DEPTH-1];

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = {c[14:0], 1'b0} ^ (((c[15] ^ b) == 1'b1) ? `CRC_POLY : 16'h0000);
  endfunction

  // ******************************
  // link side state (sck domain)
  // ******************************
  spi_crc_pkg::frame_state_t st, next_st, curSt;
  logic        fresh;
  logic        frameTog;
  logic [2:0]  bitCnt, next_bitCnt, curBit;
  logic [9:0]  byteCnt, next_byteCnt, curByte;
  logic [15:0] shiftIn, next_shiftIn, sh;
  logic [3:0]  cmd, next_cmd;
  logic [11:0] addr, next_addr, ramNext, fetchAddr;
  logic [9:0]  dataLen, next_dataLen, cntLen;
  logic [15:0] crcCalc, next_crcCalc, curCrc, crcNew;
  logic        crcBad, next_crcBad, complete, next_complete;
  logic        isRam, next_isRam, hdrRam, inBit, byteEnd, bad;
  logic [31:0] wordBuf, next_wordBuf, fetchWord;
  logic [7:0]  txByte, next_txByte;
  logic        wrPend, next_wrPend, wrWord, next_wrWord;
  logic [11:0] wrAddr, next_wrAddr;
  logic [31:0] wrData, next_wrData;
  logic [1:0]  lane;

  // frame start marker, set while chip select is high
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // one toggle per frame tells the system side a real frame happened
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      frameTog <= 1'b0;
    end else if (fresh) begin
      frameTog <= ~frameTog;
    end
  end

  // next values of the frame parser
  always_comb begin
    curSt = fresh ? spi_crc_pkg::ST_HDR : st;
    curBit = fresh ? 3'h0 : bitCnt;
    curByte = fresh ? 10'h000 : byteCnt;
    curCrc = fresh ? `CRC_INIT : crcCalc;
    // read data is covered as it leaves
    inBit = (curSt == spi_crc_pkg::ST_DATA && cmd == `CMD_READ_CRC) ? txByte[~curBit] : sdi;
    crcNew = crcStep(curCrc, inBit);
    sh = {shiftIn[14:0], sdi};
    byteEnd = (curBit == 3'h7);
    lane = curByte[1:0];
    hdrRam = (sh[11:0] >= `RAM_LO) && (sh[11:0] <= `RAM_HI);
    cntLen = isRam ? {sh[7:0], 2'b00} : {2'b00, sh[7:0]};
    ramNext = (addr[11:2] == `RAM_HI >> 2) ? `RAM_LO : 12'(addr + 12'h004);
    fetchAddr = (curSt == spi_crc_pkg::ST_DATA) ? ramNext : addr;
    fetchWord = {mem[{fetchAddr[11:2], 2'h0}], mem[{fetchAddr[11:2], 2'h1}],
                 mem[{fetchAddr[11:2], 2'h2}], mem[{fetchAddr[11:2], 2'h3}]};
    bad = (sh != curCrc);
    next_st = curSt;
    next_bitCnt = 3'(curBit + 3'h1);
    next_byteCnt = curByte;
    next_shiftIn = sh;
    next_cmd = cmd;
    next_addr = addr;
    next_dataLen = dataLen;
    next_crcCalc = curCrc;
    next_crcBad = fresh ? 1'b0 : crcBad;
    next_complete = fresh ? 1'b0 : complete;
    next_isRam = isRam;
    next_wordBuf = wordBuf;
    next_txByte = txByte;
    next_wrPend = 1'b0;
    next_wrWord = wrWord;
    next_wrAddr = wrAddr;
    next_wrData = wrData;
    if (curSt == spi_crc_pkg::ST_HDR || curSt == spi_crc_pkg::ST_COUNT || curSt == spi_crc_pkg::ST_DATA) begin
      next_crcCalc = crcNew;
    end
    case (curSt)
      spi_crc_pkg::ST_HDR: begin
        if (byteEnd) begin
          next_byteCnt = 10'(curByte + 10'h001);
          if (curByte == `HDR_LAST_BYTE) begin
            next_byteCnt = 10'h000;
            next_cmd = sh[15:12];
            next_isRam = hdrRam;
            next_addr = hdrRam ? {sh[11:2], 2'b00} : sh[11:0];
            case (sh[15:12])
              `CMD_WRITE_CRC, `CMD_READ_CRC: begin
                next_st = spi_crc_pkg::ST_COUNT;
              end
              // verified write has a fixed length
              `CMD_WRITE_SAFE: begin
                next_st = spi_crc_pkg::ST_DATA;
                next_dataLen = hdrRam ? `SAFE_RAM_LEN : `SAFE_SFR_LEN;
              end
              default: begin
                next_st = spi_crc_pkg::ST_IGNORE;
              end
            endcase
          end
        end
      end
      spi_crc_pkg::ST_COUNT: begin
        if (byteEnd) begin
          next_dataLen = cntLen;
          next_byteCnt = 10'h000;
          next_st = (cntLen == 10'h000) ? spi_crc_pkg::ST_CRC : spi_crc_pkg::ST_DATA;
          if (cmd == `CMD_READ_CRC) begin
            // first word fetched after the count
            next_wordBuf = fetchWord;
            next_txByte = isRam ? fetchWord[31:24] : mem[addr];
            if (cntLen == 10'h000) begin
              next_txByte = crcNew[15:8];
            end
          end
        end
      end
      spi_crc_pkg::ST_DATA: begin
        if (byteEnd) begin
          next_byteCnt = 10'(curByte + 10'h001);
          if (cmd == `CMD_READ_CRC) begin
            if (!isRam) begin
              next_addr = 12'(addr + 12'h001);
              next_txByte = mem[12'(addr + 12'h001)];
            end else if (lane == `LANE_LAST) begin
              // next word fetched after each fourth byte
              next_addr = ramNext;
              next_wordBuf = fetchWord;
              next_txByte = fetchWord[31:24];
            end else begin
              next_wordBuf = {wordBuf[23:0], 8'h00};
              next_txByte = wordBuf[23:16];
            end
          end else begin
            // verified data is only held here
            next_wordBuf = {wordBuf[23:0], sh[7:0]};
          end
          if (cmd == `CMD_WRITE_CRC) begin
            if (isRam && lane == `LANE_LAST) begin
              next_wrPend = 1'b1;
              next_wrWord = 1'b1;
              next_wrAddr = addr;
              next_wrData = {wordBuf[23:0], sh[7:0]};
              next_addr = ramNext;
            end else if (!isRam) begin
              // byte stored before the crc is known
              next_wrPend = 1'b1;
              next_wrWord = 1'b0;
              next_wrAddr = addr;
              next_wrData = {24'h000000, sh[7:0]};
              next_addr = 12'(addr + 12'h001);
            end
          end
          if (10'(curByte + 10'h001) == dataLen) begin
            next_st = spi_crc_pkg::ST_CRC;
            next_byteCnt = 10'h000;
            next_txByte = crcNew[15:8];
          end
        end
      end
      spi_crc_pkg::ST_CRC: begin
        if (byteEnd) begin
          next_byteCnt = 10'(curByte + 10'h001);
          next_txByte = curCrc[7:0];
          if (curByte == `CRC_LAST_BYTE) begin
            next_complete = 1'b1;
            next_st = spi_crc_pkg::ST_DONE;
            // reads never judge their own crc
            if (cmd != `CMD_READ_CRC) begin
              next_crcBad = bad;
              // verified write commits on a match only
              if (!bad && cmd == `CMD_WRITE_SAFE) begin
                next_wrPend = 1'b1;
                next_wrWord = isRam;
                next_wrAddr = addr;
                next_wrData = isRam ? wordBuf : {24'h000000, wordBuf[7:0]};
              end
            end
          end
        end
      end
      default: begin
        next_st = curSt;
      end
    endcase
  end

  // parser registers; initial values come in through the fresh marker
  always_ff @(posedge sck) begin
    st <= next_st;
    bitCnt <= next_bitCnt;
    byteCnt <= next_byteCnt;
    shiftIn <= next_shiftIn;
    cmd <= next_cmd;
    addr <= next_addr;
    dataLen <= next_dataLen;
    crcCalc <= next_crcCalc;
    crcBad <= next_crcBad;
    complete <= next_complete;
    isRam <= next_isRam;
    wordBuf <= next_wordBuf;
    txByte <= next_txByte;
    wrPend <= next_wrPend;
    wrWord <= next_wrWord;
    wrAddr <= next_wrAddr;
    wrData <= next_wrData;
  end

  // store lands on the falling edge after the eighth bit
  always_ff @(negedge sck) begin
    if (wrPend) begin
      if (wrWord) begin
        for (int i = 0; i < 4; i++) begin
          mem[{wrAddr[11:2], 2'(i)}] <= wrData[8 * (3 - i) +: 8];
        end
      end else begin
        mem[wrAddr] <= wrData[7:0];
      end
    end
  end

  // serial out msb first, changed on the falling edge
  always_ff @(negedge sck or posedge reset) begin
    if (reset) begin
      sdo <= 1'b0;
    end else begin
      sdo <= txByte[~bitCnt];
    end
  end

  // ******************************
  // system side (clk domain)
  // ******************************
  logic       csS1, csS2, csS3, togS1, togS2, seenTog, next_seenTog;
  logic       next_crcErrorFlag, next_crcFormErrorFlag, csRise, newFrame, crcCmd;
  logic [15:0] next_crcStatus;

  // two flop synchronisers for chip select and the frame toggle
  always_ff @(posedge clk) begin
    if (reset) begin
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csS3 <= 1'b1;
      togS1 <= 1'b0;
      togS2 <= 1'b0;
    end else begin
      csS1 <= csN;
      csS2 <= csS1;
      csS3 <= csS2;
      togS1 <= frameTog;
      togS2 <= togS1;
    end
  end

  // frame results are read once sck has stopped, so they are stable
  always_comb begin
    csRise = csS2 & ~csS3;
    newFrame = (togS2 != seenTog);
    crcCmd = (st != spi_crc_pkg::ST_HDR) && (st != spi_crc_pkg::ST_IGNORE);
    next_seenTog = seenTog;
    next_crcErrorFlag = crcErrorFlag & ~clearCrcError;
    next_crcFormErrorFlag = crcFormErrorFlag & ~clearFormError;
    next_crcStatus = crcStatus;
    if (csRise && newFrame) begin
      next_seenTog = togS2;
      if (crcCmd && !complete) begin
        // frame cut short, set wins over clear
        // a cut read is flagged the same way
        next_crcFormErrorFlag = 1'b1;
      end else if (crcCmd && crcBad) begin
        // mismatch flagged, set wins over clear
        next_crcErrorFlag = 1'b1;
        next_crcStatus = crcCalc;
      end
    end
  end

  // flag registers
  always_ff @(posedge clk) begin
    if (reset) begin
      seenTog <= 1'b0;
      crcErrorFlag <= 1'b0;
      crcFormErrorFlag <= 1'b0;
      crcStatus <= 16'h0000;
    end else begin
      seenTog <= next_seenTog;
      crcErrorFlag <= next_crcErrorFlag;
      crcFormErrorFlag <= next_crcFormErrorFlag;
      crcStatus <= next_crcStatus;
    end
  end

  // ******************************
  // checks
  // ******************************
  property p_frame_start;
    @(posedge sck) disable iff (reset) fresh |=> (st == spi_crc_pkg::ST_HDR) && (bitCnt == 3'h1);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not restart");
  property p_crc_init;
    @(posedge sck) disable iff (reset) fresh |=> crcCalc == crcStep(16'hffff, $past(sdi));
  endproperty
  a_crc_init: assert property (p_crc_init) else $error("crc not seeded with ones");
  property p_no_bad_commit;
    @(posedge sck) disable iff (reset) (st == spi_crc_pkg::ST_DONE && crcBad && cmd == `CMD_WRITE_SAFE) |-> !wrPend;
  endproperty
  a_no_bad_commit: assert property (p_no_bad_commit) else $error("bad verified write committed");
  property p_read_no_err;
    @(posedge sck) disable iff (reset) (st == spi_crc_pkg::ST_DONE && cmd == `CMD_READ_CRC) |-> !crcBad;
  endproperty
  a_read_no_err: assert property (p_read_no_err) else $error("read judged its crc");
  property p_ram_aligned;
    @(posedge sck) disable iff (reset) (isRam && st == spi_crc_pkg::ST_DATA) |-> addr[1:0] == 2'h0;
  endproperty
  a_ram_aligned: assert property (p_ram_aligned) else $error("memory address not aligned");
  property p_word_store;
    @(posedge sck) disable iff (reset)
      (wrPend && wrWord && cmd == `CMD_WRITE_CRC) |-> $past(byteCnt[1:0]) == 2'h3 && $past(bitCnt) == 3'h7;
  endproperty
  a_word_store: assert property (p_word_store) else $error("partial word stored");
  property p_form_err;
    @(posedge clk) disable iff (reset) (csRise && newFrame && crcCmd && !complete) |=> crcFormErrorFlag [*2];
  endproperty
  a_form_err: assert property (p_form_err) else $error("form error not flagged");
  property p_crc_err;
    @(posedge clk) disable iff (reset)
      (csRise && newFrame && crcCmd && complete && crcBad) |=> crcErrorFlag && crcStatus == $past(crcCalc);
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("crc error not flagged");
  property p_status_hold;
    @(posedge clk) disable iff (reset) !(csRise && newFrame) |=> $stable(crcStatus);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("crc status changed");
endmodule

//--- spi_crc_params.svh
// constants of the crc protected spi command handler
`ifndef SPI_CRC_PARAMS_SVH
`define SPI_CRC_PARAMS_SVH
`define CMD_WRITE_CRC  4'ha
`define CMD_READ_CRC   4'hb
`define CMD_WRITE_SAFE 4'hc
`define RAM_LO         12'h400
`define RAM_HI         12'hbff
`define CRC_INIT       16'hffff
`define CRC_POLY       16'h8005
`define HDR_LAST_BYTE  10'h001
`define CRC_LAST_BYTE  10'h001
`define SAFE_RAM_LEN   10'h004
`define SAFE_SFR_LEN   10'h001
`define LANE_LAST      2'h3
`endif

//--- spi_crc_pkg.sv
// types of the crc protected spi command handler
package spi_crc_pkg;
  typedef enum logic [2:0] {
    ST_HDR,
    ST_COUNT,
    ST_DATA,
    ST_CRC,
    ST_DONE,
    ST_IGNORE
  } frame_state_t;
endpackage

//--- spi_host_model.sv
// host side spi master model driving the crc command handler
`timescale 1ns/1ps
module spi_host_model (
  output logic      sck,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo
);
  logic [7:0] tx [0:63];
  logic [7:0] rx [0:63];

  // ****************
  // idle bus
  // ****************
  // clock parked low, nothing selected; select is raised after time 0
  // so the device sees a real rising edge and arms its frame marker
  initial begin
    sck = 1'b0;
    csN = 1'b0;
    sdi = 1'b0;
    #1 csN = 1'b1;
  end

  // all-ones start, poly, wire order
  // bytes from rdFrom on are the ones the device sent
  function automatic logic [15:0] crc16(input int len, input int rdFrom);
    logic [15:0] c;
    logic [7:0]  b;
    c = 16'hffff;
    for (int i = 0; i < len; i++) begin
      b = (i >= rdFrom) ? rx[i] : tx[i];
      for (int k = 7; k >= 0; k--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction

  // select held for the whole frame
  // mode 0, 15 ns period; clock only runs inside the frame
  task automatic run(input int bits);
    csN = 1'b0;
    #20;
    for (int i = 0; i < bits; i++) begin
      sdi = tx[i/8][7-i%8];
      #7.5 sck = 1'b1;
      rx[i/8][7-i%8] = sdo;
      #7.5 sck = 1'b0;
    end
    #10 csN = 1'b1;
    sdi = ~sdi;  // no stale bit left on a released line
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the crc protected spi command handler
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin fails++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        clk;
  logic        reset;
  logic        clearCrcError;
  logic        clearFormError;
  logic        sck;
  logic        csN;
  logic        sdi;
  logic        sdo;
  logic        crcErrorFlag;
  logic        crcFormErrorFlag;
  logic [15:0] crcStatus;
  logic [15:0] expCrc;
  logic [7:0]  dat [0:7];
  int          fails;
  int          checksDone;
  int          cycles;

  spi_crc_command_handler #(.MEM_DEPTH(4096)) u_dut (.clk(clk), .reset(reset), .sck(sck), .csN(csN), .sdi(sdi),
    .clearCrcError(clearCrcError), .clearFormError(clearFormError), .sdo(sdo), .crcErrorFlag(crcErrorFlag),
    .crcFormErrorFlag(crcFormErrorFlag), .crcStatus(crcStatus));
  spi_host_model u_host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo));

  // ****************
  // clock, timeout, verdict
  // ****************
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // a hang costs at most a few times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************
  // helpers
  // ****************
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic put(input int at, input logic [31:0] v);
    {dat[at], dat[at+1], dat[at+2], dat[at+3]} = v;
  endtask

  // write frame; bad flips the last crc bit, cut stops early (in bits)
  task automatic wr(input logic [3:0] cmd, input logic [11:0] a, input int n, input int nb, input bit bad,
                    input int cut);
    int h;
    h = (cmd == 4'hc) ? 2 : 3;
    u_host.tx[0] = {cmd, a[11:8]};
    u_host.tx[1] = a[7:0];
    u_host.tx[2] = n[7:0];
    for (int i = 0; i < nb; i++) u_host.tx[h+i] = dat[i];
    expCrc = u_host.crc16(h + nb, 64);
    u_host.tx[h+nb] = expCrc[15:8];
    u_host.tx[h+nb+1] = expCrc[7:0] ^ {7'h00, bad};
    u_host.run((cut > 0) ? cut : (h + nb + 2) * 8);
    idle(12);
  endtask

  // checked read, compares data against dat and the trailing crc
  task automatic rd(input logic [11:0] a, input int n, input int nb, input int cut);
    u_host.tx[0] = {4'hb, a[11:8]};
    u_host.tx[1] = a[7:0];
    u_host.tx[2] = n[7:0];
    for (int i = 3; i < 64; i++) u_host.tx[i] = 8'h00;
    u_host.run((cut > 0) ? cut : (nb + 5) * 8);
    idle(12);
    if (cut == 0) begin
      for (int i = 0; i < nb; i++) `CHK(u_host.rx[3+i], dat[i])
      `CHK({u_host.rx[3+nb], u_host.rx[4+nb]}, u_host.crc16(3 + nb, 3))
    end
  endtask

  // compare both flags, then clear them and see them drop
  task automatic flags(input logic ce, input logic fe);
    `CHK(crcErrorFlag, ce)
    `CHK(crcFormErrorFlag, fe)
    @(posedge clk);
    clearCrcError <= 1'b1;
    clearFormError <= 1'b1;
    idle(1);
    clearCrcError <= 1'b0;
    clearFormError <= 1'b0;
    idle(2);
    `CHK({crcErrorFlag, crcFormErrorFlag}, 2'b00)
  endtask

  // ****************
  // scenarios
  // ****************
  // register burst across the top of the space
  task automatic t_burst();
    put(0, 32'ha53c0f00);
    wr(4'ha, 12'hffe, 3, 3, 1'b0, 0);
    flags(1'b0, 1'b0);
    rd(12'hffe, 3, 3, 0);
    flags(1'b0, 1'b0);
    $display("done burst");
  endtask

  // bytes land before the crc is judged, status keeps the computed crc
  task automatic t_badcrc();
    put(0, 32'h77000000);
    wr(4'ha, 12'h020, 1, 1, 1'b1, 0);
    `CHK(crcStatus, expCrc)
    flags(1'b1, 1'b0);
    rd(12'h020, 1, 1, 0);
    $display("done badcrc");
  endtask

  // verified register write: refused on bad crc, taken on good
  task automatic t_safe_reg();
    put(0, 32'h11000000);
    wr(4'hc, 12'h020, 0, 1, 1'b1, 0);
    flags(1'b1, 1'b0);
    put(0, 32'h77000000);
    rd(12'h020, 1, 1, 0);
    put(0, 32'h11000000);
    wr(4'hc, 12'h020, 0, 1, 1'b0, 0);
    flags(1'b0, 1'b0);
    rd(12'h020, 1, 1, 0);
    $display("done safe_reg");
  endtask

  // verified memory word, unaligned addresses fold down
  task automatic t_safe_ram();
    put(0, 32'hdeadbeef);
    wr(4'hc, 12'h403, 0, 4, 1'b0, 0);
    flags(1'b0, 1'b0);
    rd(12'h401, 1, 4, 0);
    put(0, 32'h01020304);
    wr(4'hc, 12'h400, 0, 4, 1'b1, 0);
    flags(1'b1, 1'b0);
    put(0, 32'hdeadbeef);
    rd(12'h400, 1, 4, 0);
    $display("done safe_ram");
  endtask

  // torn memory write keeps the old second word, then a two word read
  task automatic t_ram_cut();
    put(0, 32'h55aa55aa);
    wr(4'hc, 12'h414, 0, 4, 1'b0, 0);
    put(0, 32'h11223344);
    put(4, 32'h99887766);
    wr(4'ha, 12'h410, 2, 8, 1'b0, 72);
    flags(1'b0, 1'b1);
    put(4, 32'h55aa55aa);
    rd(12'h410, 2, 8, 0);
    $display("done ram_cut");
  endtask

  // read cut inside the crc; host drops what it got
  task automatic t_read_cut();
    rd(12'h020, 1, 1, 40);
    flags(1'b0, 1'b1);
    $display("done read_cut");
  endtask

  // reset, then the scenarios in turn
  initial begin
    // reset rises after time 0 so the asynchronous link side flops see an edge
    reset = 1'b0;
    clearCrcError = 1'b0;
    clearFormError = 1'b0;
    fails = 0;
    checksDone = 0;
    cycles = 0;
    @(posedge clk);
    reset <= 1'b1;
    idle(5);
    reset <= 1'b0;
    idle(6);
    t_burst();
    t_badcrc();
    t_safe_reg();
    t_safe_ram();
    t_ram_cut();
    t_read_cut();
    results();
  end
endmodule
